// ### inc/dmscp_pkg.sv
// Shared constants and types for the dual mode serial control port
package dmscp_pkg;
   // Four-level pin encoding
   typedef enum logic [1:0] {
      LVL_LOW = 2'h0,
      LVL_RES = 2'h1,
      LVL_FLOAT = 2'h2,
      LVL_HIGH = 2'h3
   } dmscp_level_t;
   // Interface choice
   typedef enum logic [1:0] {
      IFS_SMBUS = 2'h0,
      IFS_SPI = 2'h1,
      IFS_SAVE = 2'h2,
      IFS_RSVD = 2'h3
   } dmscp_ifsel_t;
   localparam logic [6:0] SMB_ADDR_BASE = 7'h1D;
   localparam int SMB_BYTE_BITS = 8;
   localparam int SPI_FRAME_BITS = 17;
   localparam logic [7:0] SPI_DUMMY_ADDR = 8'hFF;
   localparam int SPI_FLAG_POS = 16;
   localparam int SPI_ADDR_MSB = 15;
   localparam int SPI_ADDR_LSB = 8;
   localparam int CLK_PERIOD_NS = 10;
   localparam int LINK_HALF_NS = 80;
   localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REG_COUNT = 256;
endpackage : dmscp_pkg

// ### inc/dmscp_if.sv
// Serial link between host and control port: SMBus and SPI pins
`timescale 1ns/1ps
interface dmscp_if;
   logic scl;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda;
   logic mosi;
   logic miso_o;
   logic miso_oe;
   logic ss_b;
   // Open drain wire: low if any enabled driver pulls low
   assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));
   modport device (
      input scl, sda, mosi, ss_b,
      output sda_dev_o, sda_dev_oe, miso_o, miso_oe
   );
   modport host (
      input sda, miso_o, miso_oe,
      output scl, sda_host_o, sda_host_oe, mosi, ss_b
   );
endinterface : dmscp_if

// ### hw/dmscp_device.sv
// Device end: mode pick, SMBus slave and 17-bit SPI shift register
`timescale 1ns/1ps
// How it works
// RULE_01: Select pin level picks SMBus, SPI or save
// RULE_02: Host keeps select pin steady after power-up
// RULE_03: Straps latched at reset give addresses 1D-2C
// RULE_04: Master puts address above a zero write bit
// RULE_05: Detect start and stop on SDA while SCL high
// RULE_06: Nine clocks per byte, ninth is acknowledge
// RULE_07: Write: address, register, data, each acknowledged, stop
// RULE_08: Read: register, repeated start, data, final no-acknowledge
// RULE_09: 17-bit frames under select; MISO floats when high
// RULE_10: Flag, address, data shifted most significant first
// RULE_11: Previous frame shifts out while new shifts in
// RULE_12: MISO driver enabled at once on select low
// RULE_13: Write executes on select rising edge
// RULE_14: Read needs a second dummy frame to 0xFF
// RULE_15: Daisy chain holds select for 17 times N
// RULE_16: Frames start on rising clock, sampled rising
// RULE_17: MISO changes on falling clock edges
// RULE_18: Acknowledge only own address, else stay released
module dmscp_device (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Straps and select pin
   input wire dmscp_pkg::dmscp_level_t mode_select_i,
   input wire dmscp_pkg::dmscp_level_t address_strap_first_i,
   input wire dmscp_pkg::dmscp_level_t address_strap_second_i,
   // Link pins
   dmscp_if.device link,
   // Status
   output logic [1:0] iface_o,
   output logic power_save_o,
   output logic [6:0] slave_addr_o
);
   import dmscp_pkg::*;

   typedef enum logic [5:0] {
      SM_IDLE = 6'h01,
      SM_SHIFT = 6'h02,
      SM_ACK = 6'h04,
      SM_SEND = 6'h08,
      SM_MACK = 6'h10,
      SM_WAIT = 6'h20
   } dmscp_smb_t;

   typedef struct packed {
      logic strapped;
      logic [1:0] iface;
      logic [6:0] saddr;
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic [2:0] sck_s;
      logic [2:0] ss_s;
      logic [1:0] mosi_s;
      dmscp_smb_t st;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic [1:0] phase;
      logic rd;
      logic [7:0] ptr;
      logic sda_low;
      logic [16:0] spi_sh;
      logic miso;
      logic started;
   } dmscp_state_t;

   dmscp_state_t s_reg;
   dmscp_state_t s_next;
   logic [7:0] mem [REG_COUNT];
   logic mem_we;
   logic [7:0] mem_wa;
   logic [7:0] mem_wd;

   // Strap level to index, used for both straps
   function automatic logic [1:0] dmscp_lvl_idx(input dmscp_level_t l);
      unique case (l)
         LVL_LOW: dmscp_lvl_idx = 2'h0;
         LVL_RES: dmscp_lvl_idx = 2'h1;
         LVL_FLOAT: dmscp_lvl_idx = 2'h2;
         LVL_HIGH: dmscp_lvl_idx = 2'h3;
      endcase
   endfunction : dmscp_lvl_idx

   logic scl_rise, scl_fall, sda_rise, sda_fall, scl_hi, sck_rise, sck_fall, ss_rise, ss_low;
   always_comb begin
      scl_hi = s_reg.scl_s[1];
      scl_rise = s_reg.scl_s[1] && !s_reg.scl_s[2];
      scl_fall = !s_reg.scl_s[1] && s_reg.scl_s[2];
      sda_rise = s_reg.sda_s[1] && !s_reg.sda_s[2];
      sda_fall = !s_reg.sda_s[1] && s_reg.sda_s[2];
      sck_rise = s_reg.sck_s[1] && !s_reg.sck_s[2];
      sck_fall = !s_reg.sck_s[1] && s_reg.sck_s[2];
      ss_rise = s_reg.ss_s[1] && !s_reg.ss_s[2];
      ss_low = !s_reg.ss_s[1];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_next = s_reg;
      mem_we = 1'b0;
      mem_wa = s_reg.ptr;
      mem_wd = s_reg.sh;
      // Pins pass two flops before use; bit 0 feeds bit 1 only
      s_next.scl_s = {s_reg.scl_s[1:0], link.scl};
      s_next.sda_s = {s_reg.sda_s[1:0], link.sda};
      s_next.sck_s = {s_reg.sck_s[1:0], link.scl};
      s_next.ss_s = {s_reg.ss_s[1:0], link.ss_b};
      s_next.mosi_s = {s_reg.mosi_s[0], link.mosi};
      // Latch select pin and straps once after reset release
      if (!s_reg.strapped) begin
         s_next.strapped = 1'b1;
         unique case (mode_select_i) // [RULE_01] [RULE_02]
            LVL_LOW: s_next.iface = IFS_SMBUS;
            LVL_FLOAT: s_next.iface = IFS_SPI;
            LVL_HIGH: s_next.iface = IFS_SAVE;
            LVL_RES: s_next.iface = IFS_RSVD;
         endcase
         s_next.saddr = SMB_ADDR_BASE + {3'h0, dmscp_lvl_idx(address_strap_first_i), // [RULE_03]
            dmscp_lvl_idx(address_strap_second_i)};
      end else if (s_reg.iface == IFS_SMBUS) begin
         // SMBus slave
         if (scl_fall) begin
            s_next.sda_low = 1'b0;
         end
         unique case (s_reg.st)
            SM_IDLE, SM_WAIT: begin
            end
            SM_SHIFT: if (scl_rise) begin // [RULE_06]
               s_next.sh = {s_reg.sh[6:0], s_reg.sda_s[1]};
               s_next.bitn = s_reg.bitn + 4'h1;
            end else if (scl_fall && s_reg.bitn == 4'(SMB_BYTE_BITS)) begin
               s_next.bitn = 4'h0;
               s_next.st = SM_ACK;
               if (s_reg.phase == 2'h0) begin
                  // Address byte: upper seven bits, low bit is direction
                  if (s_reg.sh[7:1] == s_reg.saddr) begin // [RULE_04] [RULE_18]
                     s_next.sda_low = 1'b1;
                     s_next.rd = s_reg.sh[0];
                  end else begin
                     s_next.st = SM_WAIT;
                  end
               end else begin
                  s_next.sda_low = 1'b1; // [RULE_07]
                  if (s_reg.phase == 2'h1) begin
                     s_next.ptr = s_reg.sh;
                  end else begin
                     mem_we = 1'b1;
                     mem_wa = s_reg.ptr;
                     mem_wd = s_reg.sh;
                     s_next.ptr = s_reg.ptr + 8'h01;
                  end
               end
            end
            SM_ACK: if (scl_fall) begin // [RULE_06]
               s_next.sda_low = 1'b0;
               if (s_reg.phase == 2'h0 && s_reg.rd) begin
                  s_next.st = SM_SEND; // [RULE_08]
                  s_next.sh = mem[s_reg.ptr];
                  s_next.sda_low = !mem[s_reg.ptr][7];
               end else begin
                  s_next.st = SM_SHIFT;
                  s_next.phase = (s_reg.phase == 2'h0) ? 2'h1 : 2'h2;
               end
            end
            SM_SEND: if (scl_fall) begin
               s_next.bitn = s_reg.bitn + 4'h1;
               s_next.sh = {s_reg.sh[6:0], 1'b1};
               if (s_reg.bitn == 4'(SMB_BYTE_BITS - 1)) begin
                  s_next.st = SM_MACK; // Release for master's answer
                  s_next.bitn = 4'h0;
               end else begin
                  s_next.sda_low = !s_reg.sh[6];
               end
            end
            SM_MACK: if (scl_rise) begin
               if (s_reg.sda_s[1]) begin
                  s_next.st = SM_WAIT; // [RULE_08] no acknowledge ends it
               end else begin
                  // Next byte is loaded and shown on the coming fall
                  s_next.st = SM_ACK;
                  s_next.ptr = s_reg.ptr + 8'h01;
               end
            end
            default: s_next.st = SM_IDLE;
         endcase
         // Start and stop outrank all bit activity
         if (scl_hi && sda_fall) begin // [RULE_05]
            s_next.st = SM_SHIFT;
            s_next.bitn = 4'h0;
            s_next.phase = 2'h0;
            s_next.sda_low = 1'b0;
         end else if (scl_hi && sda_rise) begin // [RULE_05]
            s_next.st = SM_IDLE;
            s_next.sda_low = 1'b0;
         end
      end else if (s_reg.iface != IFS_RSVD) begin
         // SPI slave; power save keeps SPI alive
         if (!ss_low) begin
            s_next.started = 1'b0; // [RULE_09] MOSI ignored
         end else if (sck_rise) begin // [RULE_16] [RULE_10] [RULE_15]
            s_next.started = 1'b1;
            s_next.spi_sh = {s_reg.spi_sh[15:0], s_reg.mosi_s[1]};
         end else if (sck_fall && s_reg.started) begin
            s_next.miso = s_reg.spi_sh[16]; // [RULE_17] [RULE_11]
         end
         if (ss_low && !s_reg.started) begin
            s_next.miso = s_reg.spi_sh[16];
         end
         if (ss_rise) begin // [RULE_13]
            if (!s_reg.spi_sh[SPI_FLAG_POS]) begin
               mem_we = 1'b1;
               mem_wa = s_reg.spi_sh[SPI_ADDR_MSB:SPI_ADDR_LSB];
               mem_wd = s_reg.spi_sh[7:0];
            end else begin
               // Read: load data so the next frame returns it [RULE_14]
               s_next.spi_sh[7:0] = mem[s_reg.spi_sh[SPI_ADDR_MSB:SPI_ADDR_LSB]];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_reg <= '{st: SM_IDLE, scl_s: 3'h7, sda_s: 3'h7, sck_s: 3'h7, ss_s: 3'h7, miso: 1'b1, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   // Register array; no reset so it maps to memory
   always_ff @(posedge clk_i) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drives
   always_comb begin
      link.sda_dev_o = 1'b0;
      link.sda_dev_oe = s_reg.iface == IFS_SMBUS && s_reg.strapped && s_reg.sda_low; // [RULE_18]
      link.miso_o = s_reg.miso;
      // Enabled from select alone, no clock needed [RULE_12] [RULE_09]
      link.miso_oe = s_reg.strapped && (s_reg.iface == IFS_SPI || s_reg.iface == IFS_SAVE) && !link.ss_b;
   end
   assign iface_o = s_reg.iface;
   assign power_save_o = s_reg.iface == IFS_SAVE;
   assign slave_addr_o = s_reg.saddr;
endmodule : dmscp_device

// ### hw/dmscp_host.sv
// Host end: SMBus and SPI master issuing single register accesses
`timescale 1ns/1ps
module dmscp_host (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // User request
   input wire logic req_i,
   input wire logic use_spi_i,
   input wire logic rd_i,
   input wire logic [6:0] saddr_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic busy_o,
   output logic done_o,
   output logic ack_err_o,
   output logic [7:0] rdata_o,
   // Link pins
   dmscp_if.host link
);
   import dmscp_pkg::*;

   typedef enum logic [3:0] {
      HS_IDLE = 4'h1,
      HS_RUN = 4'h2,
      HS_END = 4'h4,
      HS_DONE = 4'h8
   } dmscp_hst_t;

   typedef struct packed {
      dmscp_hst_t st;
      logic [7:0] div;
      logic [1:0] ph;
      logic [6:0] step;
      logic spi;
      logic rd;
      logic [6:0] sa;
      logic [7:0] ad;
      logic [7:0] wd;
      logic [33:0] tx;
      logic [7:0] rx;
      logic err;
      logic scl;
      logic sda_low;
      logic ss_b;
      logic mosi;
      logic [1:0] sda_s;
      logic [1:0] miso_s;
      logic done;
   } dmscp_host_state_t;

   dmscp_host_state_t h_reg;
   dmscp_host_state_t h_next;
   logic tick;
   logic [6:0] nbits;
   // SMBus acknowledge clocks; a read spends step 18 on its restart
   logic ack_slot;

   always_comb begin
      tick = h_reg.div == 8'(LINK_HALF_CYC - 1);
      nbits = h_reg.spi ? (h_reg.rd ? 7'd34 : 7'd17) : (h_reg.rd ? 7'd39 : 7'd27);
      ack_slot = h_reg.step == 7'd8 || h_reg.step == 7'd17 || h_reg.step == (h_reg.rd ? 7'd27 : 7'd26);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer sequencer: each step is one link bit of two half periods
   always_comb begin
      h_next = h_reg;
      h_next.done = 1'b0;
      h_next.sda_s = {h_reg.sda_s[0], link.sda};
      h_next.miso_s = {h_reg.miso_s[0], link.miso_o};
      h_next.div = tick ? 8'h00 : h_reg.div + 8'h01;
      unique case (h_reg.st)
         HS_IDLE: if (req_i) begin
            h_next = '{st: HS_RUN, spi: use_spi_i, rd: rd_i, sa: saddr_i, ad: addr_i, wd: wdata_i,
               scl: !use_spi_i, ss_b: 1'b1, sda_low: !use_spi_i, mosi: 1'b0, default: '0};
            // SPI frame image: flag, address, data, then dummy 0xFF read
            h_next.tx = use_spi_i ? {rd_i, addr_i, rd_i ? 8'hFF : wdata_i, 1'b1, SPI_DUMMY_ADDR, 8'hFF} :
               {saddr_i, 1'b0, addr_i, rd_i ? {saddr_i, 1'b1} : wdata_i, 10'h000}; // [RULE_04]
            h_next.sda_s = h_reg.sda_s;
            h_next.miso_s = h_reg.miso_s;
         end
         HS_RUN: if (tick) begin
            h_next.ph = h_reg.ph + 2'h1;
            if (h_reg.spi) begin
               // SPI: select low, data set on low, rising edge samples
               h_next.ss_b = 1'b0;
               if (h_reg.ph == 2'h2) begin
                  // Gap between read frames; raising select on a clock edge would lose bit 17
                  h_next.ss_b = 1'b1;
                  h_next.ph = 2'h0;
               end else if (h_reg.ph == 2'h0) begin
                  h_next.scl = 1'b0;
                  h_next.mosi = h_reg.tx[33];
                  h_next.tx = {h_reg.tx[32:0], 1'b0};
               end else begin
                  h_next.scl = 1'b1;
                  h_next.rx = {h_reg.rx[6:0], h_reg.miso_s[1]};
                  h_next.ph = (h_reg.step == 7'(SPI_FRAME_BITS - 1) && h_reg.rd) ? 2'h2 : 2'h0;
                  h_next.step = h_reg.step + 7'h01;
                  if (h_reg.step == nbits - 7'h01) begin
                     h_next.st = HS_END;
                  end
               end
            end else begin
               // SMBus: 9 clocks a byte, SDA changes while SCL low
               if (h_reg.ph == 2'h2) begin
                  h_next.sda_low = 1'b1; // Repeated start: SDA falls with SCL high
                  h_next.ph = 2'h0;
               end else if (h_reg.ph == 2'h0) begin
                  h_next.scl = 1'b0;
                  if (ack_slot || h_reg.step >= 7'd28 || (h_reg.rd && h_reg.step == 7'd18)) begin
                     h_next.sda_low = 1'b0; // Released for ack, read data or restart
                  end else begin
                     h_next.sda_low = !h_reg.tx[33];
                     h_next.tx = {h_reg.tx[32:0], 1'b0};
                  end
               end else begin
                  h_next.scl = 1'b1;
                  h_next.ph = (h_reg.rd && h_reg.step == 7'd18) ? 2'h2 : 2'h0;
                  h_next.step = h_reg.step + 7'h01;
                  if (ack_slot && h_reg.sda_s[1]) begin
                     h_next.err = 1'b1;
                  end
                  if (h_reg.step >= 7'd28 && h_reg.step < 7'd36) begin
                     h_next.rx = {h_reg.rx[6:0], h_reg.sda_s[1]};
                  end
                  if (h_reg.rd && h_reg.step == 7'd17) begin
                     h_next.tx = {h_reg.sa, 1'b1, 26'h0};
                  end
                  // Read ends on a ninth clock left high: no acknowledge
                  if (h_reg.step == (h_reg.rd ? 7'd36 : 7'd26)) begin
                     h_next.st = HS_END;
                  end
               end
            end
         end
         HS_END: if (tick) begin
            h_next.ph = h_reg.ph + 2'h1;
            if (h_reg.spi) begin
               h_next.ss_b = 1'b1;
               h_next.st = HS_DONE;
            end else if (h_reg.ph == 2'h0) begin
               h_next.scl = 1'b0;
               h_next.sda_low = 1'b1;
            end else if (h_reg.ph == 2'h1) begin
               h_next.scl = 1'b1;
            end else begin
               h_next.sda_low = 1'b0; // Stop
               h_next.st = HS_DONE;
            end
         end
         HS_DONE: begin
            h_next.done = 1'b1;
            h_next.st = HS_IDLE;
            h_next.scl = !h_reg.spi;
         end
         default: h_next.st = HS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         h_reg <= '{st: HS_IDLE, scl: 1'b1, ss_b: 1'b1, sda_s: 2'h3, default: '0};
      end else begin
         h_reg <= h_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pins and user outputs
   always_comb begin
      link.scl = h_reg.scl;
      link.sda_host_o = 1'b0;
      link.sda_host_oe = h_reg.sda_low;
      link.mosi = h_reg.mosi;
      link.ss_b = h_reg.ss_b;
   end
   assign busy_o = h_reg.st != HS_IDLE;
   assign done_o = h_reg.done;
   assign ack_err_o = h_reg.err;
   assign rdata_o = h_reg.rx;
endmodule : dmscp_host

// ### tb/dmscp_assertions.sv
// Link checker for the host and device ends of the control port
`timescale 1ns/1ps
module dmscp_assertions #(
   parameter logic [6:0] OWN_ADDR = 7'h1D
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Link signals
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_dev_oe,
   input wire logic sda_host_oe,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic ss_b
);
   logic scl_reg;
   logic sda_reg;
   logic [5:0] bit_reg;
   logic [7:0] shift_reg;
   logic [4:0] spi_reg;
   logic rise;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   assign rise = scl && !scl_reg;
   ////////////////////////////////////////////////////////////////////////////
   // Bits since start, parked at 3F outside a transfer so SPI traffic is ignored
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         bit_reg <= 6'h3F;
         shift_reg <= 8'h00;
         spi_reg <= 5'h00;
      end else begin
         scl_reg <= scl;
         sda_reg <= sda;
         if (scl && scl_reg && sda_reg && !sda) begin
            bit_reg <= 6'h00;
         end else if (scl && scl_reg && !sda_reg && sda) begin
            bit_reg <= 6'h3F;
         end else if (rise && bit_reg < 6'h28) begin
            bit_reg <= bit_reg + 6'h01;
         end
         if (rise) begin
            shift_reg <= {shift_reg[6:0], sda};
         end
         if (ss_b) begin
            spi_reg <= 5'h00;
         end else if (rise) begin
            spi_reg <= spi_reg + 5'h01;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Two flop sampling in the device allows a few cycles of lag
   AST_MISO_FLOAT: assert property (ss_b [*5] |-> !miso_oe)
      else $error("miso driven while deselected");
   AST_MISO_ENABLE: assert property ($fell(ss_b) |-> ##[0:4] miso_oe)
      else $error("miso not enabled after select");
   AST_MISO_STEADY: assert property ($rose(scl) && !ss_b |=> $stable(miso_o) [*3])
      else $error("miso moved near rising clock");
   AST_FRAME_LEN: assert property ($rose(ss_b) |-> spi_reg == 5'h11)
      else $error("spi frame not 17 clocks");
   AST_ADDR_QUIET: assert property (rise && bit_reg < 6'h08 |-> !sda_dev_oe)
      else $error("device drove sda in address byte");
   AST_ACK_RELEASE: assert property (rise && bit_reg == 6'h08 |-> !sda_host_oe)
      else $error("host held sda on ack clock");
   AST_ACK_OWN: assert property (rise && bit_reg == 6'h08 |-> sda_dev_oe == (shift_reg[7:1] == OWN_ADDR))
      else $error("ack does not follow address match");
   AST_SDA_STEADY: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
      else $error("device moved sda while scl high");
   // Main scenarios reached
   cover property ($rose(ss_b) && spi_reg == 5'h11);
   cover property (rise && bit_reg == 6'h08 && sda_dev_oe);
   cover property (rise && bit_reg == 6'h08 && !sda_dev_oe);
endmodule : dmscp_assertions

// ### tb/dual_mode_serial_control_port_tb.sv
// Bench joining host and device ends over the serial link
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("ERROR %s expected %h seen %h", what, exp, got); end end
module dual_mode_serial_control_port_tb;
   import dmscp_pkg::*;
   logic clk_i;
   logic rst_b_i;
   dmscp_level_t mode_sel;
   dmscp_level_t strap_a;
   dmscp_level_t strap_b;
   logic req, use_spi, rd, busy, done, ack_err, psave;
   logic [6:0] saddr, slave_addr;
   logic [7:0] addr, wdata, rdata, smb_byte;
   logic [1:0] iface;
   logic scl_q = 1'b1, sda_q = 1'b1, ss_q = 1'b1;
   logic [16:0] mosi_sh, miso_sh;
   int sbits = 8, fbits = 0, checks = 0, bad_count = 0;
   dmscp_if lnk();
   dmscp_device dmscp_device_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .mode_select_i(mode_sel),
      .address_strap_first_i(strap_a), .address_strap_second_i(strap_b), .link(lnk.device),
      .iface_o(iface), .power_save_o(psave), .slave_addr_o(slave_addr));
   dmscp_host dmscp_host_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .use_spi_i(use_spi), .rd_i(rd),
      .saddr_i(saddr), .addr_i(addr), .wdata_i(wdata), .busy_o(busy), .done_o(done), .ack_err_o(ack_err),
      .rdata_o(rdata), .link(lnk.host));
   dmscp_assertions #(.OWN_ADDR(7'h26)) dmscp_assertions_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl(lnk.scl),
      .sda(lnk.sda), .sda_dev_oe(lnk.sda_dev_oe), .sda_host_oe(lnk.sda_host_oe), .miso_o(lnk.miso_o),
      .miso_oe(lnk.miso_oe), .ss_b(lnk.ss_b));
   ////////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Wire monitor: first byte after a start, and whole select frames
   always @(posedge clk_i) begin
      scl_q <= lnk.scl;
      sda_q <= lnk.sda;
      ss_q <= lnk.ss_b;
      if (lnk.scl && scl_q && sda_q && !lnk.sda) sbits <= 0;
      if (!lnk.ss_b && ss_q) fbits <= 0;
      if (lnk.scl && !scl_q) begin
         if (sbits < 8) begin
            smb_byte <= {smb_byte[6:0], lnk.sda};
            sbits <= sbits + 1;
         end
         if (!lnk.ss_b) begin
            mosi_sh <= {mosi_sh[15:0], lnk.mosi};
            miso_sh <= {miso_sh[15:0], lnk.miso_o};
            fbits <= fbits + 1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Pin levels are only taken at power-up, so every mode change needs a reset
   task automatic reset_dut(input dmscp_level_t m, input dmscp_level_t a, input dmscp_level_t b);
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      mode_sel <= m;
      strap_a <= a;
      strap_b <= b;
      repeat (8) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
   endtask : reset_dut
   // One host request, waited on under a bound
   task automatic xfer(input logic spi, input logic r, input logic [6:0] sa, input logic [7:0] ad,
                       input logic [7:0] wd);
      int n;
      @(posedge clk_i);
      req <= 1'b1;
      use_spi <= spi;
      rd <= r;
      saddr <= sa;
      addr <= ad;
      wdata <= wd;
      @(posedge clk_i);
      req <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (done !== 1'b1 && n < 4000);
      if (n >= 4000) begin
         bad_count++;
         $display("ERROR done_o expected 1 seen %b", done);
         tally_and_finish();
      end
   endtask : xfer
   task automatic test_modes();
      logic [1:0] exp_if [4] = '{IFS_SMBUS, IFS_RSVD, IFS_SPI, IFS_SAVE};
      for (int i = 0; i < 4; i++) begin
         reset_dut(dmscp_level_t'(i), LVL_LOW, LVL_LOW);
         `CHK("iface_o", exp_if[i], iface)
         `CHK("power_save_o", (i == 3), psave)
      end
   endtask : test_modes
   task automatic test_straps();
      for (int i = 0; i < 4; i++) begin
         for (int j = 0; j < 4; j++) begin
            reset_dut(LVL_LOW, dmscp_level_t'(i), dmscp_level_t'(j));
            `CHK("slave_addr_o", SMB_ADDR_BASE + 7'(4 * i + j), slave_addr)
         end
      end
   endtask : test_straps
   // Back-to-back writes and reads, then a stranger address that must not land
   task automatic test_smbus();
      reset_dut(LVL_LOW, LVL_FLOAT, LVL_RES);
      xfer(1'b0, 1'b0, 7'h26, 8'h33, 8'h5A);
      `CHK("command byte", 8'h4C, smb_byte)
      `CHK("ack_err_o", 1'b0, ack_err)
      xfer(1'b0, 1'b0, 7'h26, 8'h34, 8'hC3);
      xfer(1'b0, 1'b1, 7'h26, 8'h33, 8'h00);
      `CHK("read command byte", 8'h4D, smb_byte)
      `CHK("rdata_o", 8'h5A, rdata)
      xfer(1'b0, 1'b1, 7'h26, 8'h34, 8'h00);
      `CHK("rdata_o", 8'hC3, rdata)
      xfer(1'b0, 1'b0, 7'h27, 8'h33, 8'hEE);
      `CHK("ack_err_o", 1'b1, ack_err)
      xfer(1'b0, 1'b1, 7'h26, 8'h33, 8'h00);
      `CHK("rdata_o", 8'h5A, rdata)
      `CHK("ack_err_o", 1'b0, ack_err)
   endtask : test_smbus
   task automatic test_spi();
      reset_dut(LVL_FLOAT, LVL_LOW, LVL_LOW);
      // Fill the dummy-read address so later shift-outs carry no unknowns
      xfer(1'b1, 1'b0, 7'h00, SPI_DUMMY_ADDR, 8'h00);
      xfer(1'b1, 1'b0, 7'h00, 8'h10, 8'hA5);
      `CHK("frame bits", 17, fbits)
      `CHK("mosi frame", {1'b0, 8'h10, 8'hA5}, mosi_sh)
      xfer(1'b1, 1'b0, 7'h00, 8'h11, 8'h3C);
      `CHK("miso frame", {1'b0, 8'h10, 8'hA5}, miso_sh)
      xfer(1'b1, 1'b1, 7'h00, 8'h10, 8'h00);
      `CHK("rdata_o", 8'hA5, rdata)
      `CHK("dummy address", SPI_DUMMY_ADDR, mosi_sh[15:8])
      `CHK("miso read frame", {1'b1, 8'h10, 8'hA5}, miso_sh)
      xfer(1'b1, 1'b1, 7'h00, 8'h11, 8'h00);
      `CHK("rdata_o", 8'h3C, rdata)
      // Power save keeps the serial port alive
      reset_dut(LVL_HIGH, LVL_LOW, LVL_LOW);
      xfer(1'b1, 1'b0, 7'h00, 8'h20, 8'h96);
      xfer(1'b1, 1'b1, 7'h00, 8'h20, 8'h00);
      `CHK("rdata_o", 8'h96, rdata)
   endtask : test_spi
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_b_i = 1'b0;
      mode_sel = LVL_LOW;
      strap_a = LVL_LOW;
      strap_b = LVL_LOW;
      req = 1'b0;
      use_spi = 1'b0;
      rd = 1'b0;
      saddr = 7'h00;
      addr = 8'h00;
      wdata = 8'h00;
      test_modes();
      test_straps();
      test_smbus();
      test_spi();
      tally_and_finish();
   end
endmodule : dual_mode_serial_control_port_tb
